// file: src/sfpp_top.sv
// byte/page program command sequencer of a serial flash
`include "sfpp_params.svh"
`default_nettype none
// ---------------------------------------------------------------
// Summary of operation
// - program starts only with the write enable latch set
// - opcode 02h, three address bytes, then bytes into page buffer
// - opcode A2h, address single line, data two bits per clock
// - dual data MSB first: bit 7 on bidir line, bit 6 on input
// - bytes past page end wrap to the start of the same page
// - over 256 bytes: only the last 256 stay in the buffer
// - array write starts at chip select release, walking from the first byte of the page
// - page bytes that got no data stay untouched
// - array write self-timed: page time, shorter single-byte time
// - abort unless address, one full byte, byte-aligned release
// - protected or locked start sector: no program, back to idle
// - those aborts clear the write enable latch
// - busy shows while the array cycle runs
// - write enable latch clears before a good cycle ends
// - a byte that fails to program sets the error flag
// ---------------------------------------------------------------

module sfpp_top
    import sfpp_pkg::*;
#(
    parameter int unsigned NSECT      = `SFPP_NSECT,
    parameter int unsigned SECT_SHIFT = `SFPP_SECT_SHIFT,
    parameter int unsigned PP_CYC     = `SFPP_PP_CYC,
    parameter int unsigned BP_CYC     = `SFPP_BP_CYC
) (
    input  wire logic                      I_CLK,
    input  wire logic                      I_RSTN,
    input  wire logic                      I_CS_N,
    input  wire logic                      I_SCK,
    input  wire logic                      I_SI,
    input  wire logic                      I_BDL,
    output logic                           O_BDL,
    output logic                           O_BDL_OE_N,
    input  wire logic                      I_WEN_SET,
    input  wire logic [NSECT-1:0]          I_SECT_PROT,
    input  wire logic [NSECT-1:0]          I_SECT_LOCK,
    output logic                           O_WEN,
    output logic                           O_BUSY,
    output logic                           O_PER,
    output logic                           O_ARR_WR,
    output logic [`SFPP_ADDR_BITS-1:0]     O_ARR_ADDR,
    output logic [7:0]                     O_ARR_DATA,
    input  wire logic                      I_ARR_RDY,
    input  wire logic                      I_ARR_FAIL
);

    // ---------------------------------------------------------------
    // sizes and elaboration checks
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = `SFPP_ADDR_BITS;
    localparam int unsigned PAGE_W = `SFPP_PAGE_W;
    localparam int unsigned PAGE_N = 1 << PAGE_W;
    localparam int unsigned SECT_W = (NSECT > 1) ? $clog2(NSECT) : 1;
    localparam int unsigned MAXC   = (PP_CYC > BP_CYC) ? PP_CYC : BP_CYC;
    localparam int unsigned TMR_W  = $clog2(MAXC) + 1;
    localparam int unsigned BUF_W  = ADDR_W + 8;

    if (PP_CYC < 1 || BP_CYC < 1 || NSECT < 1 ||
        SECT_SHIFT < PAGE_W || SECT_SHIFT + SECT_W > ADDR_W) begin : g_chk
        $error("sfpp_top: parameter values not supported");
    end

    // ---------------------------------------------------------------
    // reset release and pin sampling
    // ---------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;
    logic sck_reg;
    logic cs_n_reg;
    logic sck_rise;
    logic cs_rise;

    // async assert, release through two flops
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // previous pin levels for edge detection (modes 0 and 3)
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sck_reg  <= 1'b0;
            cs_n_reg <= 1'b1;
        end else begin
            sck_reg  <= I_SCK;
            cs_n_reg <= I_CS_N;
        end
    end

    assign sck_rise = I_SCK & ~sck_reg & ~I_CS_N;
    assign cs_rise  = I_CS_N & ~cs_n_reg;

    // the device never drives the bidir line while programming
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_BDL      <= 1'b0;
            O_BDL_OE_N <= 1'b1;
        end else begin
            O_BDL      <= 1'b0;
            O_BDL_OE_N <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // frame decoding
    // ---------------------------------------------------------------
    sfpp_state_t         state_reg;
    logic                dual_reg;
    logic [7:0]          shift_reg;
    logic [2:0]          bit_cnt_reg;
    logic [4:0]          addr_cnt_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic [ADDR_W-1:0]   addr_next;
    logic [7:0]          byte_next;
    logic [2:0]          bit_cnt_next;
    logic                byte_done;
    logic                opc_done;
    logic                is_prog_opc;
    logic [PAGE_W-1:0]   wptr_reg;
    logic [PAGE_W:0]     nbytes_reg;
    logic [PAGE_N-1:0]   mask_reg;
    logic [7:0]          page_mem [PAGE_N];
    logic [SECT_W-1:0]   sect;
    logic                prot_hit;
    logic                cmd_end;
    logic                prog_start;
    logic                wen_reg;
    logic                busy_reg;
    logic                per_reg;
    logic [PAGE_W:0]     idx_reg;
    logic [TMR_W-1:0]    tmr_reg;
    logic                walk_valid;
    logic                buf_rdy;
    logic                prog_done;

    // next shifted byte; dual carries two bits per clock
    always_comb begin
        if (dual_reg && state_reg == ST_DATA) begin
            byte_next    = {shift_reg[5:0], I_BDL, I_SI};
            bit_cnt_next = bit_cnt_reg + 3'h2;
        end else begin
            byte_next    = {shift_reg[6:0], I_SI};
            bit_cnt_next = bit_cnt_reg + 3'h1;
        end
    end

    assign addr_next   = {addr_reg[ADDR_W-2:0], I_SI};
    assign opc_done    = sck_rise && state_reg == ST_OPC &&
                         bit_cnt_reg == `SFPP_OPC_LAST;
    assign is_prog_opc = byte_next == `SFPP_OPC_PROG ||
                         byte_next == `SFPP_OPC_PROG_DUAL;
    assign byte_done   = sck_rise && state_reg == ST_DATA &&
                         bit_cnt_next == 3'h0;

    // target sector of the start address
    assign sect     = addr_reg[SECT_SHIFT +: SECT_W];
    assign prot_hit = I_SECT_PROT[sect] | I_SECT_LOCK[sect];

    // a program frame ends; start only when every check holds
    assign cmd_end    = cs_rise &&
                        (state_reg == ST_ADDR || state_reg == ST_DATA);
    assign prog_start = cmd_end && state_reg == ST_DATA &&
                        bit_cnt_reg == 3'h0 &&
                        nbytes_reg != '0 &&
                        wen_reg &&
                        !prot_hit;

    // command phase sequencing
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_OPC;
        end else begin
            unique case (state_reg)
                ST_OPC: begin
                    if (opc_done) begin
                        state_reg <= is_prog_opc ? ST_ADDR : ST_IGN;
                    end
                end
                ST_ADDR: begin
                    if (cs_rise) begin
                        state_reg <= ST_OPC;
                    end else if (sck_rise &&
                                 addr_cnt_reg == `SFPP_ADDR_LAST) begin
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (cs_rise) begin
                        state_reg <= prog_start ? ST_PROG : ST_OPC;
                    end
                end
                ST_IGN: begin
                    if (cs_rise) begin
                        state_reg <= ST_OPC;
                    end
                end
                ST_PROG: begin
                    // a frame already running when done is skipped whole
                    if (prog_done) begin
                        state_reg <= I_CS_N ? ST_OPC : ST_IGN;
                    end
                end
            endcase
        end
    end

    // bit position within a byte, restarted at each frame
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 5'h0;
        end else if (I_CS_N) begin
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 5'h0;
        end else if (sck_rise) begin
            if (state_reg == ST_OPC || state_reg == ST_DATA) begin
                bit_cnt_reg <= bit_cnt_next;
            end
            if (state_reg == ST_ADDR) begin
                addr_cnt_reg <= addr_cnt_reg + 5'h1;
            end
        end
    end

    // shift register, mode and start address capture
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
            dual_reg  <= 1'b0;
            addr_reg  <= '0;
        end else if (sck_rise && state_reg != ST_PROG) begin
            shift_reg <= byte_next;
            if (opc_done) begin
                dual_reg <= byte_next == `SFPP_OPC_PROG_DUAL;
            end
            if (state_reg == ST_ADDR) begin
                addr_reg <= addr_next;
            end
        end
    end

    // byte count, wrapping write pointer and written-byte mask
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg   <= '0;
            nbytes_reg <= '0;
            mask_reg   <= '0;
        end else if (opc_done) begin
            nbytes_reg <= '0;
            mask_reg   <= '0;
        end else if (sck_rise && state_reg == ST_ADDR &&
                     addr_cnt_reg == `SFPP_ADDR_LAST) begin
            wptr_reg <= addr_next[PAGE_W-1:0];
        end else if (byte_done) begin
            // pointer stays in the page, later bytes overwrite older
            wptr_reg           <= wptr_reg + 1'b1;
            mask_reg[wptr_reg] <= 1'b1;
            if (!nbytes_reg[PAGE_W]) begin
                nbytes_reg <= nbytes_reg + 1'b1;
            end
        end
    end

    // page buffer storage; no reset, the mask says what is valid
    always_ff @(posedge I_CLK) begin
        if (byte_done) begin
            page_mem[wptr_reg] <= byte_next;
        end
    end

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------

    // latch clears at every program frame end, good or aborted
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wen_reg <= `SFPP_WEN_RST;
        end else if (cmd_end) begin
            wen_reg <= 1'b0;
        end else if (I_WEN_SET && !busy_reg) begin
            wen_reg <= 1'b1;
        end
    end

    // busy for the whole self-timed cycle
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= `SFPP_BUSY_RST;
        end else if (prog_start) begin
            busy_reg <= 1'b1;
        end else if (prog_done) begin
            busy_reg <= 1'b0;
        end
    end

    // error flag: a failing byte wins over the clear at a new start
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            per_reg <= `SFPP_PER_RST;
        end else if (O_ARR_WR && I_ARR_RDY && I_ARR_FAIL) begin
            per_reg <= 1'b1;
        end else if (prog_start) begin
            per_reg <= 1'b0;
        end
    end

    assign O_WEN  = wen_reg;
    assign O_BUSY = busy_reg;
    assign O_PER  = per_reg;

    // ---------------------------------------------------------------
    // self-timed array write
    // ---------------------------------------------------------------

    // duration set by byte count, no host clock needed
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tmr_reg <= '0;
        end else if (prog_start) begin
            tmr_reg <= (nbytes_reg == 1) ? TMR_W'(BP_CYC - 1)
                                         : TMR_W'(PP_CYC - 1);
        end else if (state_reg == ST_PROG && tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 1'b1;
        end
    end

    // walk the page; only marked bytes go out, the rest stay erased
    assign walk_valid = state_reg == ST_PROG && !idx_reg[PAGE_W] &&
                        mask_reg[idx_reg[PAGE_W-1:0]];

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= '0;
        end else if (prog_start) begin
            idx_reg <= '0;
        end else if (state_reg == ST_PROG && !idx_reg[PAGE_W] &&
                     (buf_rdy || !walk_valid)) begin
            idx_reg <= idx_reg + 1'b1;
        end
    end

    // done once every byte is handed over and the time has run
    assign prog_done = state_reg == ST_PROG && idx_reg[PAGE_W] &&
                       !O_ARR_WR && tmr_reg == '0;

    // array stall holds the walk, so no byte is dropped
    sfpp_buf2 #(
        .W (BUF_W)
    ) u_buf (
        .i_clk   (I_CLK),
        .i_rst_n (rst_n),
        .i_valid (walk_valid),
        .o_ready (buf_rdy),
        .i_data  ({addr_reg[ADDR_W-1:PAGE_W],
                   idx_reg[PAGE_W-1:0],
                   page_mem[idx_reg[PAGE_W-1:0]]}),
        .o_valid (O_ARR_WR),
        .i_ready (I_ARR_RDY),
        .o_data  ({O_ARR_ADDR, O_ARR_DATA})
    );

endmodule

`default_nettype wire

// file: src/sfpp_params.svh
// constants of the serial flash page program sequencer
`ifndef SFPP_PARAMS_SVH
`define SFPP_PARAMS_SVH

// ---------------------------------------------------------------
// command codes and framing
// ---------------------------------------------------------------
`define SFPP_OPC_PROG      8'h02
`define SFPP_OPC_PROG_DUAL 8'hA2
`define SFPP_ADDR_BITS     24
`define SFPP_ADDR_LAST     5'h17
`define SFPP_OPC_LAST      3'h7
`define SFPP_PAGE_W        8
`define SFPP_NSECT         64
`define SFPP_SECT_SHIFT    16

// ---------------------------------------------------------------
// timing: times in microseconds, counts derived at 10 ns clock
// ---------------------------------------------------------------
`define SFPP_CLK_PERIOD_NS 10
`define SFPP_PAGE_PROG_TIME_US 1000
`define SFPP_BYTE_PROG_TIME_US 8
`define SFPP_PP_CYC \
    ((`SFPP_PAGE_PROG_TIME_US * 1000 + `SFPP_CLK_PERIOD_NS - 1) \
    / `SFPP_CLK_PERIOD_NS)
`define SFPP_BP_CYC \
    ((`SFPP_BYTE_PROG_TIME_US * 1000 + `SFPP_CLK_PERIOD_NS - 1) \
    / `SFPP_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SFPP_WEN_RST  1'b0
`define SFPP_BUSY_RST 1'b0
`define SFPP_PER_RST  1'b0

`endif

// file: src/sfpp_pkg.sv
// types of the serial flash page program sequencer
`default_nettype none

package sfpp_pkg;

    // frame decoding and programming phases
    typedef enum logic [2:0] {
        ST_OPC,
        ST_ADDR,
        ST_DATA,
        ST_IGN,
        ST_PROG
    } sfpp_state_t;

endpackage

`default_nettype wire

// file: src/sfpp_buf2.sv
// two-entry valid/ready buffer, outputs straight from flops
`default_nettype none

module sfpp_buf2 #(
    parameter int unsigned W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);

    if (W < 1) begin : g_chk
        $error("sfpp_buf2: W must be at least 1");
    end

    logic         v1_reg;
    logic [W-1:0] d1_reg;
    logic         push;
    logic         pop;

    // ready only from the second slot, so a stall never drops a word
    assign o_ready = ~v1_reg;
    assign push    = i_valid & ~v1_reg;
    assign pop     = o_valid & i_ready;

    // head slot drives the outputs, second slot catches overflow
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            v1_reg  <= 1'b0;
            o_data  <= '0;
            d1_reg  <= '0;
        end else if (pop) begin
            o_valid <= v1_reg | push;
            o_data  <= v1_reg ? d1_reg : i_data;
            v1_reg  <= 1'b0;
            if (v1_reg && push) begin
                v1_reg <= 1'b1;
                d1_reg <= i_data;
            end
        end else if (push) begin
            if (!o_valid) begin
                o_valid <= 1'b1;
                o_data  <= i_data;
            end else begin
                v1_reg <= 1'b1;
                d1_reg <= i_data;
            end
        end
    end

endmodule

`default_nettype wire

// file: tb/sfpp_sva.sv
// port checker for the serial flash page program sequencer
`include "sfpp_params.svh"
`default_nettype none
module sfpp_sva #(
    parameter int unsigned NSECT  = `SFPP_NSECT,
    parameter int unsigned PP_CYC = `SFPP_PP_CYC,
    parameter int unsigned BP_CYC = `SFPP_BP_CYC
) (
    input wire logic                  I_CLK,
    input wire logic                  I_RSTN,
    input wire logic                  I_CS_N,
    input wire logic                  I_SCK,
    input wire logic                  I_SI,
    input wire logic                  I_BDL,
    input wire logic                  O_BDL,
    input wire logic                  O_BDL_OE_N,
    input wire logic                  I_WEN_SET,
    input wire logic [NSECT-1:0]      I_SECT_PROT,
    input wire logic [NSECT-1:0]      I_SECT_LOCK,
    input wire logic                  O_WEN,
    input wire logic                  O_BUSY,
    input wire logic                  O_PER,
    input wire logic                  O_ARR_WR,
    input wire logic [`SFPP_ADDR_BITS-1:0] O_ARR_ADDR,
    input wire logic [7:0]            O_ARR_DATA,
    input wire logic                  I_ARR_RDY,
    input wire logic                  I_ARR_FAIL
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] last_reg;
    logic        first_reg;
    int unsigned bcnt_reg;
    // busy length and last accepted address; idle restarts the length and marks the next write as first
    always_ff @(posedge I_CLK) begin
        bcnt_reg  <= O_BUSY ? bcnt_reg + 1 : 0;
        first_reg <= !O_BUSY || (first_reg && !(O_ARR_WR && I_ARR_RDY));
        if (O_ARR_WR && I_ARR_RDY) begin
            last_reg <= O_ARR_ADDR;
        end
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    sequence s_take;
        O_ARR_WR && I_ARR_RDY;
    endsequence
    sequence s_start;
        $rose(O_BUSY);
    endsequence
    property p_wen_set;
        !O_BUSY && I_WEN_SET |=> O_WEN;
    endproperty
    a_wen_set: assert property (p_wen_set)
        else $error("latch not set by enable request");
    property p_wen_off;
        s_start |-> !O_WEN;
    endproperty
    a_wen_off: assert property (p_wen_off)
        else $error("latch still set when programming starts");
    property p_cs_start;
        s_start |-> $past(I_CS_N);
    endproperty
    a_cs_start: assert property (p_cs_start)
        else $error("programming started while selected");
    property p_hold;
        O_ARR_WR && !I_ARR_RDY |=> O_ARR_WR && $stable(O_ARR_ADDR)
            && $stable(O_ARR_DATA);
    endproperty
    a_hold: assert property (p_hold)
        else $error("array word changed before acceptance");
    property p_wr_busy;
        O_ARR_WR |-> O_BUSY;
    endproperty
    a_wr_busy: assert property (p_wr_busy)
        else $error("array write while not busy");
    property p_per;
        s_take ##0 I_ARR_FAIL |=> O_PER;
    endproperty
    a_per: assert property (p_per)
        else $error("failed byte did not raise error flag");
    property p_page;
        O_ARR_WR && !first_reg |-> O_ARR_ADDR[23:8] == last_reg[23:8]
            && O_ARR_ADDR[7:0] > last_reg[7:0];
    endproperty
    a_page: assert property (p_page)
        else $error("array write left the page or went backwards");
    property p_busy_max;
        O_BUSY |-> bcnt_reg < PP_CYC + 400;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("programming ran far past page time");
    property p_busy_min;
        $fell(O_BUSY) |-> bcnt_reg >= BP_CYC - 2;
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("programming ended before byte time");
    property p_bdl;
        O_BDL_OE_N;
    endproperty
    a_bdl: assert property (p_bdl)
        else $error("device drove the bidir data line");
endmodule
`default_nettype wire

// file: tb/sfpp_host.sv
// host spi master model issuing program frames
`default_nettype none
module sfpp_host (
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      bdl
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
        bdl  = 1'b1;
    end
    // one serial clock, data changes while clock is low, 2+2 cycles
    task automatic clk2(input logic hi, input logic lo);
        @(posedge clk);
        sck <= 1'b0;
        bdl <= hi;
        si  <= lo;
        @(posedge clk);
        @(posedge clk);
        sck <= 1'b1;
        @(posedge clk);
    endtask
    // frame: opcode, ab address bits, nb bytes, xb stray bits
    task automatic send(input logic [7:0] op, input logic [23:0] ad,
                        input int ab, input int nb, input int xb,
                        input logic [7:0] base);
        logic [7:0] d;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) clk2(~bdl, op[i]);
        for (int i = 0; i < ab; i++) clk2(~bdl, ad[23-i]);
        for (int k = 0; k < nb; k++) begin
            d = base + 8'(k) + (k > 255 ? 8'h80 : 8'h00);
            if (op == 8'hA2) begin
                for (int i = 7; i > 0; i -= 2) clk2(d[i], d[i-1]);
            end else begin
                for (int i = 7; i >= 0; i--) clk2(~bdl, d[i]);
            end
        end
        for (int i = 0; i < xb; i++) clk2(~bdl, i[0]);
        // released lines do not keep their last level
        @(posedge clk);
        sck  <= 1'b0;
        si   <= ~si;
        bdl  <= ~bdl;
        cs_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: tb/sfpp_top_tb_top.sv
// self-checking testbench of the page program sequencer
`include "sfpp_params.svh"
`default_nettype none
module sfpp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PPC = 600;
    localparam int BPC = 300;
    localparam logic [7:0]  AOP [5] = '{8'h02, 8'hA2, 8'h02, 8'h02, 8'h02};
    localparam logic [23:0] AAD [5] = '{0, 0, 0, 24'h02_0010, 24'h05_0000};
    localparam int AAB [5] = '{16, 24, 24, 24, 24};
    localparam int ANB [5] = '{0, 0, 1, 1, 1};
    localparam int AXB [5] = '{0, 0, 3, 0, 0};
    logic        clk, rstn, wen_set, arr_rdy, arr_fail, stall, fail_en;
    logic [63:0] prot, lock;
    logic        cs_n, sck, si, bdl_h, o_bdl, o_oe_n;
    logic        o_wen, o_busy, o_per, o_wr;
    logic [23:0] o_addr;
    logic [7:0]  o_data;
    wire         bdl_in;
    logic [31:0] wq [$];
    int          error_cnt, check_count, cyc;
    // bidir line: host level unless the device enables its driver
    assign bdl_in = o_oe_n ? bdl_h : o_bdl;
    sfpp_host host_u (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
                      .bdl(bdl_h));
    sfpp_top #(.PP_CYC(PPC), .BP_CYC(BPC)) dut_u (
        .I_CLK(clk), .I_RSTN(rstn), .I_CS_N(cs_n), .I_SCK(sck),
        .I_SI(si), .I_BDL(bdl_in), .O_BDL(o_bdl), .O_BDL_OE_N(o_oe_n),
        .I_WEN_SET(wen_set), .I_SECT_PROT(prot), .I_SECT_LOCK(lock),
        .O_WEN(o_wen), .O_BUSY(o_busy), .O_PER(o_per), .O_ARR_WR(o_wr),
        .O_ARR_ADDR(o_addr), .O_ARR_DATA(o_data), .I_ARR_RDY(arr_rdy),
        .I_ARR_FAIL(arr_fail));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // array model, erased target assumed; stall gives 1 ready in 2
    always @(posedge clk) begin
        if (o_wr && arr_rdy) wq.push_back({o_addr, o_data});
        arr_rdy  <= !stall || cyc[0] == 1'b0;
        arr_fail <= fail_en;
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic set_wen();
        @(posedge clk);
        wen_set <= 1'b1;
        @(posedge clk);
        wen_set <= 1'b0;
        repeat (2) @(posedge clk);
        chk(o_wen, 1);
    endtask
    // one frame, then poll busy instead of waiting the worst case
    task automatic run(input logic [7:0] op, input logic [23:0] ad,
                       input int ab, input int nb, input int xb,
                       input logic [7:0] base, input logic we,
                       output int bc);
        bc = 0;
        if (we) set_wen();
        wq.delete();
        host_u.send(op, ad, ab, nb, xb, base);
        for (int i = 0; i < 2000 && o_busy !== 1'b0; i++) begin
            @(posedge clk);
            bc++;
        end
        chk(o_busy, 0);
    endtask
    task automatic t_refuse();
        int bc;
        run(8'h02, 24'h00_0010, 24, 1, 0, 8'h11, 1'b0, bc);
        chk(bc, 0);
        chk(wq.size(), 0);
        $display("t_refuse done");
    endtask
    task automatic t_single();
        int bc;
        run(8'h02, 24'h00_00FE, 24, 3, 0, 8'h40, 1'b1, bc);
        chk(wq.size(), 3);
        chk(wq[0], 32'h0000_0042);
        chk(wq[1], 32'h0000_FE40);
        chk(wq[2], 32'h0000_FF41);
        chk(o_wen, 0);
        chk(32'(bc > BPC + 100), 1);
        $display("t_single done");
    endtask
    task automatic t_dual();
        int bc;
        stall <= 1'b1;
        run(8'hA2, 24'h01_2300, 24, 260, 0, 8'h07, 1'b1, bc);
        stall <= 1'b0;
        chk(wq.size(), 256);
        for (int k = 0; k < 256; k++) begin
            chk(wq[k], {16'h0123, 8'(k), 8'h07 + 8'(k)
                + (k < 4 ? 8'h80 : 8'h00)});
        end
        $display("t_dual done");
    endtask
    task automatic t_fail();
        int bc;
        fail_en <= 1'b1;
        run(8'h02, 24'h00_0200, 24, 1, 0, 8'hA5, 1'b1, bc);
        fail_en <= 1'b0;
        chk(o_per, 1);
        chk(32'(bc < PPC - 100), 1);
        chk(wq[0], 32'h0002_00A5);
        run(8'h02, 24'h00_0300, 24, 1, 0, 8'h3C, 1'b1, bc);
        chk(o_per, 0);
        $display("t_fail done");
    endtask
    // aborts: short address, no data, stray bits, protected, locked
    task automatic t_abort();
        int bc;
        for (int c = 0; c < 5; c++) begin
            prot <= (c == 3) ? 64'h4 : 64'h0;
            lock <= (c == 4) ? 64'h20 : 64'h0;
            run(AOP[c], AAD[c], AAB[c], ANB[c], AXB[c], 8'h66, 1'b1, bc);
            chk(bc, 0);
            chk(wq.size(), 0);
            chk(o_wen, 0);
        end
        prot <= 64'h0;
        lock <= 64'h0;
        $display("t_abort done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        rstn = 1'b0;
        wen_set = 1'b0;
        stall = 1'b0;
        fail_en = 1'b0;
        prot = 64'h0;
        lock = 64'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({o_wen, o_busy, o_per, o_wr}, 0);
        t_refuse();
        t_single();
        t_dual();
        t_fail();
        t_abort();
        complete_run();
    end
endmodule
bind sfpp_top sfpp_sva #(.NSECT(NSECT), .PP_CYC(PP_CYC), .BP_CYC(BP_CYC))
    chk_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CS_N(I_CS_N),
    .I_SCK(I_SCK), .I_SI(I_SI), .I_BDL(I_BDL), .O_BDL(O_BDL),
    .O_BDL_OE_N(O_BDL_OE_N), .I_WEN_SET(I_WEN_SET),
    .I_SECT_PROT(I_SECT_PROT), .I_SECT_LOCK(I_SECT_LOCK), .O_WEN(O_WEN),
    .O_BUSY(O_BUSY), .O_PER(O_PER), .O_ARR_WR(O_ARR_WR),
    .O_ARR_ADDR(O_ARR_ADDR), .O_ARR_DATA(O_ARR_DATA),
    .I_ARR_RDY(I_ARR_RDY), .I_ARR_FAIL(I_ARR_FAIL));
`default_nettype wire
